// File: core/psg_core.sv
// Four-channel sound generator with parallel command port and PWM outputs
`default_nettype none
module psg_core (
    // Clock and reset
    input  wire logic            CLK_SYS_IN,
    input  wire logic            SYS_RST_IN,
    // Command data
    input  wire psg_pkg::sample_t DATA_IN,
    // Two-way pins
    input  wire psg_pkg::sample_t UIO_IN,
    output var  psg_pkg::sample_t UIO_OUT,
    output var  psg_pkg::sample_t UIO_OE_OUT,
    // Digital audio
    output var  psg_pkg::sample_t AUDIO_OUT
);
    import psg_pkg::*;

    function automatic chan_t cmd_channel(input sample_t b);
        cmd_channel = b[CMD_CH_HI:CMD_CH_LO];
    endfunction

    function automatic logic is_latch(input sample_t b);
        is_latch = b[CMD_LATCH_BIT];
    endfunction

    // =====================================================
    // Write strobe
    logic       we_n;
    logic       we_prev_reg;
    logic       write_strobe;
    logic       we_rise;
    logic [1:0] sel;
    chan_t      cmd_ch;

    assign we_n  = UIO_IN[UIO_WE_BIT];
    assign sel   = {UIO_IN[UIO_SEL_HI_BIT], UIO_IN[UIO_SEL_LO_BIT]};
    assign cmd_ch = cmd_channel(DATA_IN);
    // Edge detect so a long low strobe writes only once
    assign write_strobe = we_prev_reg & ~we_n;
    assign we_rise      = ~we_prev_reg & we_n;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            we_prev_reg <= 1'b1;
        end else begin
            we_prev_reg <= we_n;
        end
    end

    // =====================================================
    // Command registers
    period_t          period_reg [NUM_TONE];
    atten_t           atten_reg  [NUM_CH];
    logic [NCTRL_W-1:0] noise_ctrl_reg;
    chan_t            last_ch_reg;
    logic             last_tone_reg;
    logic             noise_pending_reg;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < NUM_TONE; i++) begin
                period_reg[i] <= '0;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                atten_reg[i] <= ATTEN_RESET;
            end
            noise_ctrl_reg <= NCTRL_RESET;
            last_ch_reg    <= '0;
            last_tone_reg  <= 1'b0;
        end else if (write_strobe) begin
            if (is_latch(DATA_IN)) begin
                last_ch_reg   <= cmd_ch;
                last_tone_reg <= ~DATA_IN[CMD_TYPE_BIT] && cmd_ch != NOISE_CH;
                if (DATA_IN[CMD_TYPE_BIT]) begin
                    atten_reg[cmd_ch] <= DATA_IN[CMD_LOW_HI:0];
                end else if (cmd_ch == NOISE_CH) begin
                    noise_ctrl_reg <= DATA_IN[NCTRL_W-1:0];
                end else begin
                    period_reg[cmd_ch][LOW_PART_W-1:0] <=
                        DATA_IN[CMD_LOW_HI:0];
                end
            end else if (last_tone_reg) begin
                period_reg[last_ch_reg][PERIOD_W-1:LOW_PART_W] <=
                    DATA_IN[CMD_HIGH_HI:0];
            end
        end
    end

    // Restart waits for the strobe to return high
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            noise_pending_reg <= 1'b0;
        end else if (write_strobe && is_latch(DATA_IN)
                     && !DATA_IN[CMD_TYPE_BIT] && cmd_ch == NOISE_CH) begin
            noise_pending_reg <= 1'b1;
        end else if (we_rise) begin
            noise_pending_reg <= 1'b0;
        end
    end

    // =====================================================
    // Prescaler
    logic [PRE_W-1:0] pre_cnt_reg;
    logic [PRE_W-1:0] pre_last;
    logic             pre_tick;

    always_comb begin
        unique case (sel)
            SEL_NONE:   pre_last = PRE_LAST_1;
            SEL_DIV128: pre_last = PRE_LAST_128;
            SEL_DIV16_A, SEL_DIV16_B: pre_last = PRE_LAST_16;
        endcase
    end
    // Compare with >= so a select change never strands the counter
    assign pre_tick = pre_cnt_reg >= pre_last;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_tick ? '0 : pre_cnt_reg + PRE_W'(1);
        end
    end

    // =====================================================
    // Tone channels: N ticks per half wave, period 0 acts as 1
    period_t tone_cnt_reg [NUM_TONE];
    logic [NUM_TONE-1:0] tone_bit_reg;
    logic [NUM_TONE-1:0] tone_reload;

    for (genvar t = 0; t < NUM_TONE; t++) begin : g_tone
        assign tone_reload[t] = pre_tick && tone_cnt_reg[t] <= period_t'(1);
        always_ff @(posedge CLK_SYS_IN) begin
            if (SYS_RST_IN) begin
                tone_cnt_reg[t] <= '0;
                tone_bit_reg[t] <= 1'b0;
            end else if (tone_reload[t]) begin
                tone_cnt_reg[t] <= period_reg[t];
                tone_bit_reg[t] <= ~tone_bit_reg[t];
            end else if (pre_tick) begin
                tone_cnt_reg[t] <= tone_cnt_reg[t] - period_t'(1);
            end
        end
    end

    // =====================================================
    // Noise generator
    logic [NDIV_W-1:0] noise_div_reg;
    logic [NDIV_W-1:0] noise_last;
    logic [LFSR_W-1:0] lfsr_reg;
    logic [1:0]        noise_rate;
    logic              noise_shift;
    logic              feedback;

    assign noise_rate = noise_ctrl_reg[NOISE_RATE_HI:0];
    always_comb begin
        noise_last  = NDIV_LAST_512;
        noise_shift = 1'b0;
        unique case (noise_rate)
            NOISE_RATE_512:  noise_last = NDIV_LAST_512;
            NOISE_RATE_1024: noise_last = NDIV_LAST_1024;
            NOISE_RATE_2048: noise_last = NDIV_LAST_2048;
            NOISE_RATE_TONE: noise_last = NDIV_LAST_2048;
        endcase
        if (noise_rate == NOISE_RATE_TONE) begin
            // Shift on each rising edge of tone channel 2
            noise_shift = tone_reload[NUM_TONE-1]
                          && !tone_bit_reg[NUM_TONE-1];
        end else begin
            noise_shift = pre_tick && (noise_div_reg & noise_last)
                          == noise_last;
        end
    end
    // Periodic mode recirculates one bit; white mode mixes two taps
    assign feedback = noise_ctrl_reg[NOISE_WHITE_BIT]
                      ? lfsr_reg[0] ^ lfsr_reg[1] : lfsr_reg[0];

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN || (noise_pending_reg && we_rise)) begin
            noise_div_reg <= '0;
            lfsr_reg      <= LFSR_SEED;
        end else begin
            if (pre_tick) begin
                noise_div_reg <= noise_div_reg + NDIV_W'(1);
            end
            if (noise_shift) begin
                lfsr_reg <= {feedback, lfsr_reg[LFSR_W-1:1]};
            end
        end
    end

    // =====================================================
    // Attenuation and mix
    logic [NUM_CH-1:0] ch_bit;
    level_t            level [NUM_CH];
    sample_t           ch_val [NUM_CH];
    sample_t           mix_next;

    assign ch_bit = {lfsr_reg[0], tone_bit_reg};

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        psg_level_table u_table (
            .clk_in    (CLK_SYS_IN),
            .rst_in    (SYS_RST_IN),
            .atten_in  (atten_reg[c]),
            .level_out (level[c])
        );
        assign ch_val[c] = ch_bit[c] ? sample_t'(level[c]) : '0;
    end

    // Four 6-bit levels peak at 252, so the sum fits 8 bits
    assign mix_next = ch_val[0] + ch_val[1] + ch_val[2] + ch_val[3];

    // =====================================================
    // PWM and outputs
    sample_t pwm_cnt_reg;
    sample_t audio_reg;
    sample_t uio_reg;
    sample_t oe_reg;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pwm_cnt_reg <= '0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + DATA_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            audio_reg <= '0;
            uio_reg   <= '0;
            oe_reg    <= UIO_OE_VALUE;
        end else begin
            audio_reg <= mix_next;
            oe_reg    <= UIO_OE_VALUE;
            uio_reg   <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                uio_reg[UIO_PWM_BASE + c] <=
                    {ch_val[c][LEVEL_W-1:0], 2'h0} > pwm_cnt_reg;
            end
            uio_reg[UIO_MASTER_BIT] <= mix_next > pwm_cnt_reg;
        end
    end

    assign AUDIO_OUT  = audio_reg;
    assign UIO_OUT    = uio_reg;
    assign UIO_OE_OUT = oe_reg;

    // =====================================================
    // Assertions
    property p_tone_low;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (write_strobe && DATA_IN[CMD_LATCH_BIT] && !DATA_IN[CMD_TYPE_BIT]
         && cmd_ch == 2'h0) |=> period_reg[0][3:0] == $past(DATA_IN[3:0]);
    endproperty
    a_tone_low: assert property (p_tone_low)
        else $error("tone low bits not loaded");

    property p_tone_high;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (write_strobe && !DATA_IN[CMD_LATCH_BIT] && last_tone_reg
         && last_ch_reg == 2'h2)
        |=> period_reg[2][9:4] == $past(DATA_IN[5:0]);
    endproperty
    a_tone_high: assert property (p_tone_high)
        else $error("tone high bits not loaded");

    property p_atten;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (write_strobe && DATA_IN[CMD_LATCH_BIT] && DATA_IN[CMD_TYPE_BIT]
         && cmd_ch == NOISE_CH) |=> atten_reg[3] == $past(DATA_IN[3:0]);
    endproperty
    a_atten: assert property (p_atten)
        else $error("attenuation not loaded");

    property p_noise_ctrl;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (write_strobe && DATA_IN[CMD_LATCH_BIT] && !DATA_IN[CMD_TYPE_BIT]
         && cmd_ch == NOISE_CH)
        |=> noise_ctrl_reg == $past(DATA_IN[2:0]) && noise_pending_reg;
    endproperty
    a_noise_ctrl: assert property (p_noise_ctrl)
        else $error("noise control not loaded or restart lost");

    property p_restart;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (noise_pending_reg && we_rise)
        |=> lfsr_reg == LFSR_SEED && !noise_pending_reg;
    endproperty
    a_restart: assert property (p_restart)
        else $error("noise not restarted after strobe rise");

    property p_prescale_16;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (pre_tick && sel == SEL_DIV16_A) ##1 (sel == SEL_DIV16_A)[*8]
        ##1 (sel == SEL_DIV16_A)[*8] |-> pre_tick;
    endproperty
    a_prescale_16: assert property (p_prescale_16)
        else $error("prescaler tick spacing not 16");

    property p_tone_toggle;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (pre_tick && tone_cnt_reg[0] <= period_t'(1))
        |=> tone_bit_reg[0] != $past(tone_bit_reg[0])
            && tone_cnt_reg[0] == $past(period_reg[0]);
    endproperty
    a_tone_toggle: assert property (p_tone_toggle)
        else $error("tone did not reload and invert");

    property p_mix;
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        ##1 AUDIO_OUT <= MIX_MAX && UIO_OE_OUT == UIO_OE_VALUE;
    endproperty
    a_mix: assert property (p_mix)
        else $error("mix overflow or pin direction wrong");

    property p_reset;
        @(posedge CLK_SYS_IN)
        SYS_RST_IN |=> period_reg[2] == '0 && noise_ctrl_reg == NCTRL_RESET
            && lfsr_reg == LFSR_SEED && pre_cnt_reg == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear state");

    c_tone_write: cover property (@(posedge CLK_SYS_IN)
        write_strobe && !DATA_IN[CMD_LATCH_BIT] && last_tone_reg);
    c_restart: cover property (@(posedge CLK_SYS_IN)
        noise_pending_reg && we_rise);
    c_master_pwm: cover property (@(posedge CLK_SYS_IN)
        UIO_OUT[UIO_MASTER_BIT]);
endmodule
`default_nettype wire

// File: shared/psg_pkg.sv
// Constants and types shared by the sound generator design files
`default_nettype none
package psg_pkg;
    // =====================================================
    // Widths
    localparam int DATA_W   = 8;
    localparam int PERIOD_W = 10;
    localparam int ATTEN_W  = 4;
    localparam int LEVEL_W  = 6;
    localparam int LFSR_W   = 15;
    localparam int PRE_W    = 7;
    localparam int NDIV_W   = 11;
    localparam int NCTRL_W  = 3;
    localparam int NUM_TONE = 3;
    localparam int NUM_CH   = 4;
    localparam int NUM_ATT  = 16;

    typedef logic [PERIOD_W-1:0] period_t;
    typedef logic [ATTEN_W-1:0]  atten_t;
    typedef logic [LEVEL_W-1:0]  level_t;
    typedef logic [DATA_W-1:0]   sample_t;
    typedef logic [1:0]          chan_t;

    // =====================================================
    // Command byte fields
    localparam int CMD_LATCH_BIT = 7;
    localparam int CMD_TYPE_BIT  = 4;
    localparam int CMD_CH_HI     = 6;
    localparam int CMD_CH_LO     = 5;
    localparam int CMD_LOW_HI    = 3;
    localparam int CMD_HIGH_HI   = 5;
    localparam int LOW_PART_W    = 4;
    localparam int HIGH_PART_W   = 6;
    localparam chan_t NOISE_CH   = 2'h3;
    localparam int NOISE_WHITE_BIT = 2;
    localparam int NOISE_RATE_HI   = 1;

    // =====================================================
    // Two-way pin map
    localparam int UIO_WE_BIT     = 0;
    localparam int UIO_SEL_LO_BIT = 1;
    localparam int UIO_SEL_HI_BIT = 2;
    localparam int UIO_PWM_BASE   = 3;
    localparam int UIO_MASTER_BIT = 7;
    localparam sample_t UIO_OE_VALUE = 8'hf8;

    // =====================================================
    // Prescaler: terminal counts and select codes
    localparam logic [1:0] SEL_DIV16_A = 2'h0;
    localparam logic [1:0] SEL_NONE    = 2'h1;
    localparam logic [1:0] SEL_DIV128  = 2'h2;
    localparam logic [1:0] SEL_DIV16_B = 2'h3;
    localparam logic [PRE_W-1:0] PRE_LAST_16  = 7'h0f;
    localparam logic [PRE_W-1:0] PRE_LAST_1   = 7'h00;
    localparam logic [PRE_W-1:0] PRE_LAST_128 = 7'h7f;

    // =====================================================
    // Noise shift rates and seed
    localparam logic [1:0] NOISE_RATE_512  = 2'h0;
    localparam logic [1:0] NOISE_RATE_1024 = 2'h1;
    localparam logic [1:0] NOISE_RATE_2048 = 2'h2;
    localparam logic [1:0] NOISE_RATE_TONE = 2'h3;
    localparam logic [NDIV_W-1:0] NDIV_LAST_512  = 11'h1ff;
    localparam logic [NDIV_W-1:0] NDIV_LAST_1024 = 11'h3ff;
    localparam logic [NDIV_W-1:0] NDIV_LAST_2048 = 11'h7ff;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h4000;
    localparam logic [NCTRL_W-1:0] NCTRL_RESET = 3'h0;
    localparam atten_t ATTEN_RESET = 4'hf;

    // =====================================================
    // Level per attenuation code, 63 * 10^(-code/20), code 15 silent
    localparam level_t LEVEL_TABLE [NUM_ATT] = '{
        6'h3f, 6'h38, 6'h32, 6'h2d, 6'h28, 6'h23, 6'h20, 6'h1c,
        6'h19, 6'h16, 6'h14, 6'h12, 6'h10, 6'h0e, 6'h0d, 6'h00};
    localparam sample_t MIX_MAX = 8'hfc;
endpackage
`default_nettype wire

// File: core/psg_level_table.sv
// Attenuation to output level lookup with registered read data
`default_nettype none
module psg_level_table (
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    // Lookup
    input  wire psg_pkg::atten_t atten_in,
    output var  psg_pkg::level_t level_out
);
    import psg_pkg::*;

    // =====================================================
    // Table read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_out <= LEVEL_TABLE[ATTEN_RESET];
        end else begin
            level_out <= LEVEL_TABLE[atten_in];
        end
    end
endmodule
`default_nettype wire

// File: verif/psg_host_model.sv
// Host model that writes command bytes over the parallel port
`default_nettype none
module psg_host_model (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Bench request
    input  wire logic             req_in,
    input  wire psg_pkg::sample_t byte_in,
    input  wire logic [1:0]       sel_in,
    output var  logic             done_out,
    // Port pins
    output var  psg_pkg::sample_t data_out,
    output var  logic [2:0]       pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import psg_pkg::*;
    // =====================================================
    // Write sequencer
    logic [2:0] step_reg;
    logic       strobe_n_reg;
    assign pins_out = {sel_in, strobe_n_reg};
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            step_reg     <= 3'h0;
            strobe_n_reg <= 1'b1;
            done_out     <= 1'b0;
            data_out     <= 8'h5a;
        end else begin
            case (step_reg)
                3'h0: if (req_in) begin
                    data_out <= byte_in;
                    step_reg <= 3'h1;
                end
                3'h1: begin
                    strobe_n_reg <= 1'b0;
                    step_reg     <= 3'h2;
                end
                3'h2: begin
                    strobe_n_reg <= 1'b1;
                    done_out     <= 1'b1;
                    step_reg     <= 3'h3;
                end
                default: begin
                    // Hold time over: stale data must not look valid
                    done_out <= 1'b0;
                    data_out <= ~data_out;
                    step_reg <= 3'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verif/psg_core_tb_top.sv
// Self-checking testbench of the sound generator core
`default_nettype none
module psg_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psg_pkg::*;
    // =====================================================
    // Signals
    logic        clk;
    logic        rst;
    logic        req;
    sample_t     cmd;
    logic [1:0]  sel;
    logic        host_done;
    sample_t     data;
    logic [2:0]  host_pins;
    sample_t     uio_in;
    sample_t     uio_out;
    sample_t     uio_oe;
    sample_t     audio;
    int          fail_count;
    int          checks;
    int          cyc;
    int          mode;
    logic [31:0] exp_q[$];
    int          div[4] = '{16, 1, 128, 16};
    chan_t       ch;
    event        go;
    event        fin;
    // Pins 0..2 come from the host only where the core does not drive
    assign uio_in = (uio_oe & uio_out) | (~uio_oe & {5'h00, host_pins});
    // =====================================================
    // Instances
    psg_core uut (
        .CLK_SYS_IN (clk),
        .SYS_RST_IN (rst),
        .DATA_IN    (data),
        .UIO_IN     (uio_in),
        .UIO_OUT    (uio_out),
        .UIO_OE_OUT (uio_oe),
        .AUDIO_OUT  (audio)
    );
    psg_host_model host (
        .clk_in   (clk),
        .rst_in   (rst),
        .req_in   (req),
        .byte_in  (cmd),
        .sel_in   (sel),
        .done_out (host_done),
        .data_out (data),
        .pins_out (host_pins)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // =====================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        checks++;
        if (seen !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, e);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input sample_t b);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        cmd <= b;
        do begin
            @(posedge clk);
            n++;
        end while (host_done !== 1'b1 && n < 20);
        // A host that never finishes counts as a mismatch
        if (host_done !== 1'b1) check(host_done, 32'h1);
        req <= 1'b0;
    endtask
    task automatic measure(input int m, input logic [31:0] e);
        exp_q.push_back(e);
        mode = m;
        @(posedge clk);
        -> go;
        @(fin);
    endtask
    // Counts from the current level to the next rise of the mix
    task automatic wait_rise(output int n);
        n = 0;
        while (audio !== 8'h00 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        while (audio === 8'h00 && n < 40000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // =====================================================
    // Result watcher
    initial begin : watcher
        int          n;
        int          pwm_hi;
        int          pwm_ch;
        logic [31:0] seen;
        forever begin
            @(go);
            seen = 0;
            if (mode == 1) begin
                repeat (72) begin
                    @(negedge clk);
                    if (audio > seen) begin
                        seen = audio;
                    end
                end
            end else begin
                // First rises may carry a stale prescaler phase
                repeat (mode == 2 ? 1 : 3) wait_rise(n);
                seen = n;
                // Long high half: one full PWM counter sweep at a steady mix
                if (mode == 3) begin
                    pwm_hi = 0;
                    pwm_ch = 0;
                    repeat (256) begin
                        pwm_hi += uio_out[UIO_MASTER_BIT];
                        pwm_ch += uio_out[UIO_PWM_BASE];
                        @(negedge clk);
                    end
                    check(pwm_hi, exp_q.pop_front());
                    check(pwm_ch, exp_q.pop_front());
                end
                if (mode == 2 && n + 16 > exp_q[0] && n < exp_q[0] + 16) begin
                    seen = exp_q[0];
                end
            end
            check(seen, exp_q.pop_front());
            -> fin;
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail_count++;
            summarize();
        end
    end
    // =====================================================
    // Stimulus
    initial begin : driver
        rst = 1'b1;
        req = 1'b0;
        cmd = 8'h00;
        sel = 2'h1;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        mode = 0;
        void'($urandom(32'h557c6695));
        ch = 2'($urandom % 3);
        repeat (12) @(posedge clk);
        @(negedge clk);
        check(audio, 8'h00);
        check(uio_out, 8'h00);
        check(uio_oe, UIO_OE_VALUE);
        @(posedge clk);
        rst <= 1'b0;
        wr({1'b1, ch, 1'b0, 4'h1});
        wr(8'h00);
        for (int c = 0; c < NUM_ATT; c++) begin
            wr({1'b1, ch, 1'b1, 4'(c)});
            measure(1, 32'(LEVEL_TABLE[c]));
        end
        wr(8'h90);
        wr(8'h82);
        wr(8'h01);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            sel <= 2'(s);
            if (s == 2) begin
                exp_q.push_back(32'(LEVEL_TABLE[0]));
                exp_q.push_back(32'({LEVEL_TABLE[0], 2'h0}));
            end
            measure(s == 2 ? 3 : 0, 36 * div[s]);
        end
        wr(8'h9f);
        @(posedge clk);
        sel <= 2'h1;
        wr(8'hc1);
        wr(8'h00);
        wr(8'hf8);
        wr(8'he7);
        repeat (50) @(posedge clk);
        wr(8'he3);
        measure(2, 28);
        measure(1, 32'(LEVEL_TABLE[8]));
        for (int r = 0; r < 3; r++) begin
            wr(8'he0 | 8'(r));
            measure(2, 14 * (512 << r));
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        measure(1, 0);
        summarize();
    end
endmodule
`default_nettype wire
